// File: core/ipr_pkg.sv
// Package: register map, field layout and reset values of the priority bank
// Functional notes
// - A three-bit priority field is read as its binary value, 111 being level seven (highest) and 001 level one (lowest).
// - A field holding 000 disables its source, which is then never offered for service.
// - Bits outside the priority fields ignore writes and always read as zero.
// - On reset every priority field loads 100.
// - Priority fields are readable and writable, and a read returns the last value written.
// - Register 5 holds the external interrupt 1 priority in bits 2-0; bits 15-3 are unused.
// - Register 6 holds timer 4 at 14-12, output compare 4 at 10-8 and output compare 3 at 6-4.
// - Register 7 holds serial 2 transmit at 14-12, receive at 10-8, external interrupt 2 at 6-4 and timer 5 at 2-0.
// - Register 8 holds sync port 2 event at 6-4 and fault at 2-0; bits 15-7 are unused.
// - Register 9 holds input capture 5 at 14-12, capture 4 at 10-8 and capture 3 at 6-4.
// - Register 10 holds output compare 5 at 6-4; all other bits read zero.
// - Register 11 holds the parallel port priority at 6-4; all other bits read zero.
package ipr_pkg;
	localparam int IPR_ADDR_W = 4;
	localparam int IPR_DATA_W = 16;
	localparam int IPR_NREG = 7;
	localparam logic [3:0] IPR_OFS_CTRL5 = 4'h0;
	localparam logic [3:0] IPR_OFS_CTRL6 = 4'h1;
	localparam logic [3:0] IPR_OFS_CTRL7 = 4'h2;
	localparam logic [3:0] IPR_OFS_CTRL8 = 4'h3;
	localparam logic [3:0] IPR_OFS_CTRL9 = 4'h4;
	localparam logic [3:0] IPR_OFS_CTRL10 = 4'h5;
	localparam logic [3:0] IPR_OFS_CTRL11 = 4'h6;
	// Implemented-bit masks, one per register
	localparam logic [15:0] IPR_MASK5 = 16'h0007;
	localparam logic [15:0] IPR_MASK6 = 16'h7770;
	localparam logic [15:0] IPR_MASK7 = 16'h7777;
	localparam logic [15:0] IPR_MASK8 = 16'h0077;
	localparam logic [15:0] IPR_MASK9 = 16'h7770;
	localparam logic [15:0] IPR_MASK10 = 16'h0070;
	localparam logic [15:0] IPR_MASK11 = 16'h0070;
	// Reset pattern 100 in every nibble; the mask trims it per register
	localparam logic [15:0] IPR_RESET_ALL = 16'h4444;
	localparam logic [2:0] IPR_PRIO_OFF = 3'h0;
	localparam logic [2:0] IPR_PRIO_RESET = 3'h4;
	localparam int IPR_FLD_HI = 12;
	localparam int IPR_FLD_MID = 8;
	localparam int IPR_FLD_LO4 = 4;
	localparam int IPR_FLD_LO0 = 0;
endpackage

// File: core/ipr_src_gate.sv
// Per-source request gate: forwards a pending source with its priority level
`timescale 1ns/10ps
module ipr_src_gate
	import ipr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [2:0] prio,
	input wire logic pending,
	output logic req_q,
	output logic [2:0] level_q
);
	logic req_d;
	logic [2:0] level_d;

	always_comb begin
		// Level 0 means disabled: never request
		req_d = pending && (prio != IPR_PRIO_OFF);
		level_d = req_d ? prio : IPR_PRIO_OFF;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			req_q <= 1'b0;
			level_q <= 3'h0;
		end else begin
			req_q <= req_d;
			level_q <= level_d;
		end
	end

	chk_disabled_silent: assert property (
		@(posedge ref_clk) disable iff (reset)
		(prio == IPR_PRIO_OFF) |=> !req_q)
		else $error("disabled source requested service");
	chk_level_follows: assert property (
		@(posedge ref_clk) disable iff (reset)
		(pending && prio != IPR_PRIO_OFF) |=>
		(req_q && level_q == $past(prio)))
		else $error("request level differs from field");
endmodule // ipr_src_gate

// File: core/ipr_bank.sv
// Priority register bank 5 to 11 with per-source priority outputs
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module ipr_bank
	import ipr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [IPR_ADDR_W-1:0] reg_addr,
	input wire logic [IPR_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [IPR_DATA_W-1:0] reg_rdata_q,
	input wire logic [14:0] src_pending,
	output logic [14:0] src_req_q,
	output logic [44:0] src_level_q,
	output logic [2:0] ext_int1_priority,
	output logic [2:0] timer4_priority,
	output logic [2:0] outcmp4_priority,
	output logic [2:0] outcmp3_priority,
	output logic [2:0] serial2_tx_priority,
	output logic [2:0] serial2_rx_priority,
	output logic [2:0] ext_int2_priority,
	output logic [2:0] timer5_priority,
	output logic [2:0] sync2_event_priority,
	output logic [2:0] sync2_fault_priority,
	output logic [2:0] incap5_priority,
	output logic [2:0] incap4_priority,
	output logic [2:0] incap3_priority,
	output logic [2:0] outcmp5_priority,
	output logic [2:0] parport_priority
);
	logic [15:0] ctrl_q [IPR_NREG];
	logic [15:0] ctrl_d [IPR_NREG];
	logic [15:0] rdata_d;
	logic [44:0] prio_all;

	// Index of the register at an offset, or IPR_NREG when unmapped
	function automatic int reg_index(input logic [IPR_ADDR_W-1:0] a);
		if (a == IPR_OFS_CTRL5) return 0;
		else if (a == IPR_OFS_CTRL6) return 1;
		else if (a == IPR_OFS_CTRL7) return 2;
		else if (a == IPR_OFS_CTRL8) return 3;
		else if (a == IPR_OFS_CTRL9) return 4;
		else if (a == IPR_OFS_CTRL10) return 5;
		else if (a == IPR_OFS_CTRL11) return 6;
		else return IPR_NREG;
	endfunction

	function automatic logic [15:0] reg_mask(input int i);
		case (i)
			0: return IPR_MASK5;
			1: return IPR_MASK6;
			2: return IPR_MASK7;
			3: return IPR_MASK8;
			4: return IPR_MASK9;
			5: return IPR_MASK10;
			6: return IPR_MASK11;
			default: return 16'h0000;
		endcase
	endfunction

	always_comb begin
		for (int i = 0; i < IPR_NREG; i++) begin
			ctrl_d[i] = ctrl_q[i];
		end
		rdata_d = 16'h0000;
		if (reg_wr && reg_index(reg_addr) < IPR_NREG) begin
			// Unused bits never store, so they read back zero
			for (int i = 0; i < IPR_NREG; i++) begin
				if (i == reg_index(reg_addr)) begin
					ctrl_d[i] = reg_wdata & reg_mask(i);
				end
			end
		end
		if (reg_rd) begin
			// Unmapped offsets read as zero
			for (int i = 0; i < IPR_NREG; i++) begin
				if (i == reg_index(reg_addr)) begin
					rdata_d = ctrl_q[i] & reg_mask(i);
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < IPR_NREG; i++) begin
				ctrl_q[i] <= IPR_RESET_ALL & reg_mask(i);
			end
			reg_rdata_q <= 16'h0000;
		end else begin
			for (int i = 0; i < IPR_NREG; i++) begin
				ctrl_q[i] <= ctrl_d[i];
			end
			reg_rdata_q <= rdata_d;
		end
	end

	// Fields come straight from the flops so a write acts on the next clock
	assign ext_int1_priority = ctrl_q[0][IPR_FLD_LO0 +: 3];
	assign timer4_priority = ctrl_q[1][IPR_FLD_HI +: 3];
	assign outcmp4_priority = ctrl_q[1][IPR_FLD_MID +: 3];
	assign outcmp3_priority = ctrl_q[1][IPR_FLD_LO4 +: 3];
	assign serial2_tx_priority = ctrl_q[2][IPR_FLD_HI +: 3];
	assign serial2_rx_priority = ctrl_q[2][IPR_FLD_MID +: 3];
	assign ext_int2_priority = ctrl_q[2][IPR_FLD_LO4 +: 3];
	assign timer5_priority = ctrl_q[2][IPR_FLD_LO0 +: 3];
	assign sync2_event_priority = ctrl_q[3][IPR_FLD_LO4 +: 3];
	assign sync2_fault_priority = ctrl_q[3][IPR_FLD_LO0 +: 3];
	assign incap5_priority = ctrl_q[4][IPR_FLD_HI +: 3];
	assign incap4_priority = ctrl_q[4][IPR_FLD_MID +: 3];
	assign incap3_priority = ctrl_q[4][IPR_FLD_LO4 +: 3];
	assign outcmp5_priority = ctrl_q[5][IPR_FLD_LO4 +: 3];
	assign parport_priority = ctrl_q[6][IPR_FLD_LO4 +: 3];

	assign prio_all = {parport_priority, outcmp5_priority, incap3_priority,
		incap4_priority, incap5_priority, sync2_fault_priority,
		sync2_event_priority, timer5_priority, ext_int2_priority,
		serial2_rx_priority, serial2_tx_priority, outcmp3_priority,
		outcmp4_priority, timer4_priority, ext_int1_priority};

	// One gate per source; request and level go to the arbiter
	for (genvar s = 0; s < 15; s++) begin : g_src
		ipr_src_gate u_gate (
			.ref_clk(ref_clk),
			.reset(reset),
			.prio(prio_all[3*s +: 3]),
			.pending(src_pending[s]),
			.req_q(src_req_q[s]),
			.level_q(src_level_q[3*s +: 3])
		);
	end

	chk_write_visible: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL7) |=>
		(serial2_tx_priority == $past(reg_wdata[14:12])
		&& timer5_priority == $past(reg_wdata[2:0])))
		else $error("written priority not visible next clock");
	chk_ext1_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL5) |=>
		ext_int1_priority == $past(reg_wdata[2:0]))
		else $error("external interrupt 1 field misplaced");
	chk_timer4_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL6) |=>
		timer4_priority == $past(reg_wdata[14:12]))
		else $error("timer 4 field misplaced");
	chk_oc4_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL6) |=>
		outcmp4_priority == $past(reg_wdata[10:8]))
		else $error("output compare 4 field misplaced");
	chk_oc3_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL6) |=>
		outcmp3_priority == $past(reg_wdata[6:4]))
		else $error("output compare 3 field misplaced");
	chk_rx2_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL7) |=>
		serial2_rx_priority == $past(reg_wdata[10:8]))
		else $error("serial 2 receive field misplaced");
	chk_ext2_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL7) |=>
		ext_int2_priority == $past(reg_wdata[6:4]))
		else $error("external interrupt 2 field misplaced");
	chk_event_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL8) |=>
		sync2_event_priority == $past(reg_wdata[6:4]))
		else $error("sync port 2 event field misplaced");
	chk_fault_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL8) |=>
		sync2_fault_priority == $past(reg_wdata[2:0]))
		else $error("sync port 2 fault field misplaced");
	chk_ic5_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL9) |=>
		incap5_priority == $past(reg_wdata[14:12]))
		else $error("input capture 5 field misplaced");
	chk_ic4_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL9) |=>
		incap4_priority == $past(reg_wdata[10:8]))
		else $error("input capture 4 field misplaced");
	chk_ic3_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL9) |=>
		incap3_priority == $past(reg_wdata[6:4]))
		else $error("input capture 3 field misplaced");
	chk_oc5_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL10) |=>
		outcmp5_priority == $past(reg_wdata[6:4]))
		else $error("output compare 5 field misplaced");
	chk_par_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL11) |=>
		parport_priority == $past(reg_wdata[6:4]))
		else $error("parallel port field misplaced");

	chk_read_masked: assert property (
		@(posedge ref_clk) disable iff (reset)
		reg_rd |=> ((reg_rdata_q & 16'h8888) == 16'h0000))
		else $error("unimplemented bit read as one");
	chk_reg6_unused: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr == IPR_OFS_CTRL6) |=>
		(reg_rdata_q & ~IPR_MASK6) == 16'h0000)
		else $error("register 6 unused bits not zero");
	chk_reg9_unused: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr == IPR_OFS_CTRL9) |=>
		(reg_rdata_q & ~IPR_MASK9) == 16'h0000)
		else $error("register 9 unused bits not zero");
	chk_reg10_unused: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr == IPR_OFS_CTRL10) |=>
		(reg_rdata_q & ~IPR_MASK10) == 16'h0000)
		else $error("register 10 unused bits not zero");
	chk_reg11_unused: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr == IPR_OFS_CTRL11) |=>
		(reg_rdata_q & ~IPR_MASK11) == 16'h0000)
		else $error("register 11 unused bits not zero");
	chk_reg5_upper: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr == IPR_OFS_CTRL5) |=>
		reg_rdata_q[15:3] == 13'h0000)
		else $error("register 5 upper bits not zero");
	chk_reg8_upper: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr == IPR_OFS_CTRL8) |=>
		reg_rdata_q[15:7] == 9'h000)
		else $error("register 8 upper bits not zero");

	chk_reset_value: assert property (
		@(posedge ref_clk)
		$fell(reset) |-> (ext_int1_priority == IPR_PRIO_RESET
		&& parport_priority == IPR_PRIO_RESET
		&& incap5_priority == IPR_PRIO_RESET))
		else $error("priority not 100 after reset");
	chk_reset_rest: assert property (
		@(posedge ref_clk)
		$fell(reset) |-> (timer4_priority == IPR_PRIO_RESET
		&& outcmp4_priority == IPR_PRIO_RESET
		&& outcmp3_priority == IPR_PRIO_RESET
		&& serial2_tx_priority == IPR_PRIO_RESET
		&& serial2_rx_priority == IPR_PRIO_RESET
		&& ext_int2_priority == IPR_PRIO_RESET
		&& timer5_priority == IPR_PRIO_RESET
		&& sync2_event_priority == IPR_PRIO_RESET
		&& sync2_fault_priority == IPR_PRIO_RESET
		&& incap4_priority == IPR_PRIO_RESET
		&& incap3_priority == IPR_PRIO_RESET
		&& outcmp5_priority == IPR_PRIO_RESET))
		else $error("priority not 100 after reset");

	chk_read_back: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL9) ##1
		(reg_rd && reg_addr == IPR_OFS_CTRL9 && !reg_wr) |=>
		(reg_rdata_q == ($past(reg_wdata, 2) & IPR_MASK9)))
		else $error("read differs from last write");
	chk_back_ctrl5: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL5) ##1
		(reg_rd && reg_addr == IPR_OFS_CTRL5 && !reg_wr) |=>
		(reg_rdata_q == ($past(reg_wdata, 2) & IPR_MASK5)))
		else $error("register 5 read differs from last write");
	chk_back_ctrl6: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL6) ##1
		(reg_rd && reg_addr == IPR_OFS_CTRL6 && !reg_wr) |=>
		(reg_rdata_q == ($past(reg_wdata, 2) & IPR_MASK6)))
		else $error("register 6 read differs from last write");
	chk_back_ctrl7: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL7) ##1
		(reg_rd && reg_addr == IPR_OFS_CTRL7 && !reg_wr) |=>
		(reg_rdata_q == ($past(reg_wdata, 2) & IPR_MASK7)))
		else $error("register 7 read differs from last write");
	chk_back_ctrl8: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == IPR_OFS_CTRL8) ##1
		(reg_rd && reg_addr == IPR_OFS_CTRL8 && !reg_wr) |=>
		(reg_rdata_q == ($past(reg_wdata, 2) & IPR_MASK8)))
		else $error("register 8 read differs from last write");

	chk_unmapped_read: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr > IPR_OFS_CTRL11) |=>
		reg_rdata_q == 16'h0000)
		else $error("unmapped offset read nonzero");
	chk_idle_read: assert property (
		@(posedge ref_clk) disable iff (reset)
		!reg_rd |=>
		reg_rdata_q == 16'h0000)
		else $error("read data stood past its cycle");
	chk_unmapped_write: assert property (
		@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr > IPR_OFS_CTRL11) |=>
		$stable(prio_all))
		else $error("unmapped write changed a field");

	cov_write_ctrl6: cover property (@(posedge ref_clk)
		reg_wr && reg_addr == IPR_OFS_CTRL6);
	cov_disable_src: cover property (@(posedge ref_clk)
		reg_wr && reg_addr == IPR_OFS_CTRL11 && reg_wdata[6:4] == 3'h0);
	cov_top_level: cover property (@(posedge ref_clk)
		src_req_q[0] && src_level_q[2:0] == 3'h7);
	cov_back_to_back: cover property (@(posedge ref_clk)
		reg_wr ##1 reg_rd);
	cov_unmapped_read: cover property (@(posedge ref_clk)
		reg_rd && reg_addr > IPR_OFS_CTRL11);
endmodule // ipr_bank

// File: bench/tb.sv
// Self-checking bench for the priority register bank and its source gates
`timescale 1ns/10ps
module tb
	import ipr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [IPR_ADDR_W-1:0] reg_addr = 4'h0;
	logic [IPR_DATA_W-1:0] reg_wdata = 16'h0;
	logic [IPR_DATA_W-1:0] reg_rdata_q;
	logic [14:0] src_pending = 15'h0;
	logic [14:0] src_req_q;
	logic [44:0] src_level_q;
	logic [2:0] ext_int1_priority, timer4_priority, outcmp4_priority;
	logic [2:0] outcmp3_priority, serial2_tx_priority, serial2_rx_priority;
	logic [2:0] ext_int2_priority, timer5_priority, sync2_event_priority;
	logic [2:0] sync2_fault_priority, incap5_priority, incap4_priority;
	logic [2:0] incap3_priority, outcmp5_priority, parport_priority;
	logic [44:0] fld;
	// Register index and low bit of each source's field, in port order
	int ri [15] = '{0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 5, 6};
	int lo [15] = '{0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 4, 4};
	logic [15:0] m [7];
	logic [15:0] msk [7];
	int failures = 0;
	int comparisons = 0;
	integer seed = 32'ha9fe860f;
	integer k;
	logic pend = 1'b0;
	logic [44:0] exp_rq, exp_lv, exp_rd, exp_fld;
	assign fld = {parport_priority, outcmp5_priority, incap3_priority,
		incap4_priority, incap5_priority, sync2_fault_priority,
		sync2_event_priority, timer5_priority, ext_int2_priority,
		serial2_rx_priority, serial2_tx_priority, outcmp3_priority,
		outcmp4_priority, timer4_priority, ext_int1_priority};
	ipr_bank dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .src_pending(src_pending),
		.src_req_q(src_req_q), .src_level_q(src_level_q),
		.ext_int1_priority(ext_int1_priority),
		.timer4_priority(timer4_priority), .outcmp4_priority(outcmp4_priority),
		.outcmp3_priority(outcmp3_priority),
		.serial2_tx_priority(serial2_tx_priority),
		.serial2_rx_priority(serial2_rx_priority),
		.ext_int2_priority(ext_int2_priority),
		.timer5_priority(timer5_priority),
		.sync2_event_priority(sync2_event_priority),
		.sync2_fault_priority(sync2_fault_priority),
		.incap5_priority(incap5_priority), .incap4_priority(incap4_priority),
		.incap3_priority(incap3_priority), .outcmp5_priority(outcmp5_priority),
		.parport_priority(parport_priority));
	always #5 ref_clk = ~ref_clk;
	function automatic logic [44:0] prio_vec();
		logic [44:0] f;
		f = '0;
		for (int s = 0; s < 15; s++)
			f[3*s+:3] = m[ri[s]][lo[s]+:3];
		return f;
	endfunction
	task check(input string name, input logic [44:0] e, input logic [44:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, e, s);
		end
	endtask
	task complete_run();
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Masks and reset values come from the field table, not the package
	task do_reset();
		reset <= 1'b1;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		settle();
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			m[i] = 16'h0;
			msk[i] = 16'h0;
		end
		for (int s = 0; s < 15; s++) begin
			m[ri[s]][lo[s]+:3] = 3'h4;
			msk[ri[s]][lo[s]+:3] = 3'h7;
		end
	endtask
	// Results of the transfer taken at the last edge, looked at mid-cycle
	task settle();
		@(negedge ref_clk);
		if (pend) begin
			check("src_req_q", exp_rq, {30'h0, src_req_q});
			check("src_level_q", exp_lv, src_level_q);
			check("reg_rdata_q", exp_rd, {29'h0, reg_rdata_q});
			check("fields", exp_fld, fld);
		end
		pend = 1'b0;
	endtask
	// Driven on one edge, taken on the next; its results are compared
	// by the settle of the following call, so transfers run back to back
	task bus(input logic w, input logic r, input logic [3:0] a,
		input logic [15:0] d, input logic [14:0] p);
		logic [44:0] f;
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		src_pending <= p;
		settle();
		f = prio_vec();
		exp_rq = '0;
		for (int s = 0; s < 15; s++) begin
			exp_rq[s] = p[s] && (f[3*s+:3] != 3'h0);
			exp_lv[3*s+:3] = exp_rq[s] ? f[3*s+:3] : 3'h0;
		end
		exp_rd = (r && a < 7) ? {29'h0, m[a]} : 45'h0;
		if (w && a < 7)
			m[a] = d & msk[a];
		exp_fld = prio_vec();
		pend = 1'b1;
		@(posedge ref_clk);
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		complete_run();
	end
	initial begin
		do_reset();
		for (int a = 0; a < 16; a++)
			bus(1'b0, 1'b1, a[3:0], 16'h0, 15'h7fff);
		for (int a = 0; a < 16; a++) begin
			bus(1'b1, 1'b0, a[3:0], 16'hffff, 15'h7fff);
			bus(1'b0, 1'b1, a[3:0], 16'h0, 15'h7fff);
		end
		for (int a = 0; a < 7; a++)
			bus(1'b1, 1'b0, a[3:0], 16'h0, 15'h7fff);
		bus(1'b0, 1'b0, 4'h0, 16'h0, 15'h7fff);
		for (int i = 0; i < 400; i++) begin
			k = $random(seed);
			bus(k[0], !k[0] && k[1], k[7:4], k[31:16], k[22:8]);
		end
		do_reset();
		for (int a = 0; a < 7; a++)
			bus(1'b0, 1'b1, a[3:0], 16'h0, 15'h5555);
		settle();
		complete_run();
	end
endmodule // tb
